// >>> rtl/grouped_interrupt_prioritizer.sv
/*
 * Top of the grouped interrupt prioritizer: register file, twelve
 * expansion groups, CPU line arbitration and the take handshake.
 * Assumes the register master and the CPU run on clk_sys, that
 * peripheral requests are one-cycle pulses on clk_sys and that the four
 * direct lines are levels on clk_sys.
 */
// The plain strobed port and the register offsets were left to the implementer.
`timescale 1ns/1ps

`include "gip_cfg.svh"

module grouped_interrupt_prioritizer
    import gip_pkg::*;
(
    input  wire logic                                     clk_sys,
    input  wire logic                                     rst,
    input  wire reg_req_t                                 regReq,
    output word_t                                         regRdata,
    input  wire logic [`GIP_NUM_GROUPS-1:0][7:0]          periphReq,
    input  wire logic [`GIP_NUM_DIRECT-1:0]               directLines,
    output logic                                          intReq,
    input  wire logic                                     intTake,
    output vector_t                                       intVector
);

    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    core_state_t                          st;
    core_state_t                          next_st;
    logic [`GIP_NUM_GROUPS-1:0]           groupLine;
    logic [`GIP_NUM_GROUPS-1:0][2:0]      groupPos;
    logic [`GIP_NUM_GROUPS-1:0][7:0]      groupPend;
    logic [`GIP_NUM_GROUPS-1:0]           groupBlocked;
    logic [`GIP_NUM_GROUPS-1:0]           groupTake;
    logic [`GIP_NUM_GROUPS-1:0]           groupAck;
    line_bits_t                           lineRaw;
    logic                                 arbReq;
    logic [3:0]                           arbWinner;
    logic                                 takeNow;
    logic                                 wrCpuEn;
    logic                                 wrCtrl;
    logic                                 wrAck;
    logic                                 rdVector;
    logic                                 grpEnHit;
    logic                                 grpPendHit;
    logic [3:0]                           grpIdx;

    // ------------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------------
    // Indices past the last group alias nothing, so they read as zero.
    function automatic logic isGroup(input logic [3:0] idx);
        return idx < 4'(`GIP_NUM_GROUPS);
    endfunction

    function automatic logic inWindow(input logic [5:0] addr,
                                      input logic [5:0] base);
        return (addr[5:4] == base[5:4]) && isGroup(addr[3:0]);
    endfunction

    assign grpIdx     = regReq.addr[3:0];
    assign grpEnHit   = inWindow(regReq.addr, `GIP_REG_GRP_EN);
    assign grpPendHit = inWindow(regReq.addr, `GIP_REG_GRP_PEND);
    assign wrCpuEn    = regReq.wr && (regReq.addr == `GIP_REG_CPU_EN);
    assign wrCtrl     = regReq.wr && (regReq.addr == `GIP_REG_CTRL);
    assign wrAck      = regReq.wr && (regReq.addr == `GIP_REG_ACK);
    assign rdVector   = regReq.rd && (regReq.addr == `GIP_REG_VECTOR);

    // ------------------------------------------------------------------
    // Expansion groups
    // ------------------------------------------------------------------
    // Each written one releases that group; all ones releases every one.
    assign groupAck = wrAck ? regReq.wdata[`GIP_NUM_GROUPS-1:0]
                            : '0;

    for (genvar g = 0; g < `GIP_NUM_GROUPS; g++) begin : gGroup
        group_expander uGroup (
            .clk_sys     (clk_sys),
            .rst         (rst),
            .periphReq   (periphReq[g]),
            .groupEnable (st.groupEn[g]),
            .ackClear    (groupAck[g]),
            .take        (groupTake[g]),
            .lineOut     (groupLine[g]),
            .posOut      (groupPos[g]),
            .pending     (groupPend[g]),
            .blocked     (groupBlocked[g])
        );
    end

    // ------------------------------------------------------------------
    // CPU lines
    // ------------------------------------------------------------------
    // Group g drives line g+1; direct lines fill thirteen to sixteen.
    // Line order alone sets the ranking, so the fast groups on lines one
    // and two beat the periodic groups on three to five, and those beat
    // the buffered serial groups on six, eight and nine.
    assign lineRaw = {directLines, groupLine};

    line_arbiter uArb (
        .lineRaw    (lineRaw),
        .cpuEn      (st.cpuEn),
        .globalMask (st.globalMask),
        .req        (arbReq),
        .winner     (arbWinner)
    );

    // The request drops as soon as the mask or enables close it, so a
    // routine running with the mask cleared is preempted by any open line.
    assign intReq  = arbReq;
    assign takeNow = intTake && arbReq;

    always_comb begin
        groupTake = '0;
        if (takeNow && isGroup(arbWinner)) begin
            groupTake[arbWinner] = 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // Register file and take
    // ------------------------------------------------------------------
    always_comb begin
        next_st       = st;
        next_st.rdata = '0;

        // Writes.
        if (wrCpuEn) begin
            next_st.cpuEn = regReq.wdata;
        end
        if (wrCtrl) begin
            next_st.globalMask = regReq.wdata[`GIP_CTRL_MASK_BIT];
        end
        if (regReq.wr && grpEnHit) begin
            next_st.groupEn[grpIdx] = regReq.wdata[7:0];
        end

        // Reading the vector consumes it.
        if (rdVector) begin
            next_st.vec.valid = 1'b0;
        end

        // A take masks further lines; it wins over a clearing write in the
        // same cycle so the entry into the routine is never left open.
        if (takeNow) begin
            next_st.globalMask = 1'b1;
            next_st.vec.valid  = 1'b1;
            next_st.vec.line   = arbWinner;
            if (isGroup(arbWinner)) begin
                next_st.vec.pos = groupPos[arbWinner];
            end else begin
                next_st.vec.pos = 3'h0;
            end
        end

        // Reads; data stand only in the following cycle.
        if (regReq.rd) begin
            if (grpEnHit) begin
                next_st.rdata = {8'h00, st.groupEn[grpIdx]};
            end else if (grpPendHit) begin
                next_st.rdata = {8'h00, groupPend[grpIdx]};
            end else begin
                unique case (regReq.addr)
                    `GIP_REG_CPU_EN: begin
                        next_st.rdata = st.cpuEn;
                    end
                    `GIP_REG_CTRL: begin
                        next_st.rdata = {15'h0000, st.globalMask};
                    end
                    `GIP_REG_ACK: begin
                        next_st.rdata = {4'h0, groupBlocked};
                    end
                    `GIP_REG_VECTOR: begin
                        next_st.rdata = {st.vec.valid, 8'h00,
                                         st.vec.line, st.vec.pos};
                    end
                    `GIP_REG_LINES: begin
                        next_st.rdata = lineRaw;
                    end
                    default: begin
                        next_st.rdata = 16'h0000;
                    end
                endcase
            end
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            st.cpuEn      <= `GIP_RST_CPU_EN;
            st.globalMask <= `GIP_RST_MASK;
            st.groupEn    <= {`GIP_NUM_GROUPS{`GIP_RST_GRP_EN}};
            st.rdata      <= 16'h0000;
            st.vec        <= '0;
        end else begin
            st <= next_st;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign regRdata  = st.rdata;
    assign intVector = st.vec;

endmodule

// >>> rtl/gip_cfg.svh
/*
 * Constants of the grouped interrupt prioritizer: sizes, register offsets,
 * field positions and reset values.
 * Assumes it is included by bare name and holds definitions only.
 */
`ifndef GIP_CFG_SVH
`define GIP_CFG_SVH

// ----------------------------------------------------------------------
// Sizes
// ----------------------------------------------------------------------
`define GIP_NUM_GROUPS   12
`define GIP_GROUP_SIZE   8
`define GIP_NUM_LINES    16
`define GIP_NUM_DIRECT   4
`define GIP_ADDR_W       6
`define GIP_DATA_W       16

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define GIP_REG_CPU_EN   6'h00
`define GIP_REG_CTRL     6'h01
`define GIP_REG_ACK      6'h02
`define GIP_REG_VECTOR   6'h03
`define GIP_REG_LINES    6'h04
`define GIP_REG_GRP_EN   6'h10
`define GIP_REG_GRP_PEND 6'h20

// ----------------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------------
`define GIP_CTRL_MASK_BIT 0
`define GIP_RST_CPU_EN   16'h0000
`define GIP_RST_MASK     1'b1
`define GIP_RST_GRP_EN   8'h00
`define GIP_ACK_ALL      16'hffff

`endif

// >>> rtl/gip_pkg.sv
/*
 * Types and shared functions of the grouped interrupt prioritizer.
 * Assumes gip_cfg.svh is on the include path.
 */
`include "gip_cfg.svh"

package gip_pkg;

    // ------------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------------
    typedef logic [`GIP_GROUP_SIZE-1:0] grp_bits_t;
    typedef logic [`GIP_NUM_LINES-1:0]  line_bits_t;
    typedef logic [`GIP_DATA_W-1:0]     word_t;

    typedef struct packed {
        logic [`GIP_ADDR_W-1:0] addr;
        word_t                  wdata;
        logic                   wr;
        logic                   rd;
    } reg_req_t;

    typedef struct packed {
        logic       valid;
        logic [3:0] line;
        logic [2:0] pos;
    } vector_t;

    // ------------------------------------------------------------------
    // State records
    // ------------------------------------------------------------------
    typedef struct packed {
        grp_bits_t pending;
        logic      blocked;
    } grp_state_t;

    typedef struct packed {
        line_bits_t                          cpuEn;
        logic                                globalMask;
        logic [`GIP_NUM_GROUPS-1:0][7:0]     groupEn;
        word_t                               rdata;
        vector_t                             vec;
    } core_state_t;

    // Lowest set bit wins; fixed order keeps the default ranking static.
    function automatic logic [3:0] lowestSet(input logic [15:0] v);
        logic [3:0] idx;
        idx = 4'h0;
        for (int i = 15; i >= 0; i--) begin
            if (v[i]) begin
                idx = 4'(i);
            end
        end
        return idx;
    endfunction

endpackage

// >>> rtl/group_expander.sv
/*
 * One expansion group: eight request flags, their enables, and the
 * acknowledge lock that holds the group line after a take.
 * Assumes request pulses come from logic on clk_sys.
 */
`timescale 1ns/1ps

module group_expander
    import gip_pkg::*;
(
    input  wire logic      clk_sys,
    input  wire logic      rst,
    input  wire grp_bits_t periphReq,
    input  wire grp_bits_t groupEnable,
    input  wire logic      ackClear,
    input  wire logic      take,
    output logic           lineOut,
    output logic [2:0]     posOut,
    output grp_bits_t      pending,
    output logic           blocked
);

    grp_state_t st;
    grp_state_t next_st;
    grp_bits_t  live;
    grp_bits_t  clearMask;
    logic [3:0] posIdx;

    assign live    = st.pending & groupEnable;
    assign posIdx  = lowestSet({8'h00, live});
    assign posOut  = posIdx[2:0];
    assign lineOut = ~st.blocked & (|live);
    assign pending = st.pending;
    assign blocked = st.blocked;

    always_comb begin
        next_st   = st;
        clearMask = '0;
        if (take) begin
            clearMask[posOut] = 1'b1;
        end
        // A new request in the same cycle as its clear is kept.
        next_st.pending = (st.pending & ~clearMask) | periphReq;
        if (take) begin
            next_st.blocked = 1'b1;
        end else if (ackClear) begin
            next_st.blocked = 1'b0;
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

endmodule

// >>> rtl/line_arbiter.sv
/*
 * CPU level arbiter: gates the sixteen lines by enable and global mask
 * and picks the lowest numbered survivor.
 * Assumes all inputs are on clk_sys; purely combinational.
 */
`timescale 1ns/1ps

module line_arbiter
    import gip_pkg::*;
(
    input  wire line_bits_t lineRaw,
    input  wire line_bits_t cpuEn,
    input  wire logic       globalMask,
    output logic            req,
    output logic [3:0]      winner
);

    line_bits_t open;

    assign open   = lineRaw & cpuEn & {16{~globalMask}};
    assign req    = |open;
    // Line one sits at bit zero, so it always outranks the rest.
    assign winner = lowestSet(open);

endmodule

// >>> verif/gip_chk.sv
/*
 * Port checker of the grouped interrupt prioritizer.
 * Assumes it is bound to the top module; one clock, reset active high.
 */
`timescale 1ns/1ps

module gip_chk
    import gip_pkg::*;
(
    input wire logic             clk_sys,
    input wire logic             rst,
    input wire reg_req_t         regReq,
    input wire word_t            regRdata,
    input wire logic [11:0][7:0] periphReq,
    input wire logic [3:0]       directLines,
    input wire logic             intReq,
    input wire logic             intTake,
    input wire vector_t          intVector
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    // --------------------
    // Assertions
    // --------------------
    chk_take_vector: assert property (
        intTake && intReq |=> intVector.valid)
        else $error("take gave no valid vector");
    chk_take_masks: assert property (
        intTake && intReq |=> !intReq)
        else $error("request still open after take");
    // Software alone may reopen delivery, so three quiet cycles must stay shut.
    chk_mask_hold: assert property (
        intTake && intReq ##1
        (!(regReq.wr && regReq.addr == 6'h01))[*3] |-> !intReq)
        else $error("request reopened without a mask write");
    chk_direct_pos: assert property (
        intTake && intReq |=>
        (intVector.line < 4'hc || intVector.pos == 3'h0))
        else $error("direct line with nonzero position");
    chk_vector_hold: assert property (
        !(intTake && intReq) |=>
        $stable(intVector.line) && $stable(intVector.pos))
        else $error("vector changed without a take");
    chk_read_clear: assert property (
        regReq.rd && regReq.addr == 6'h03 && !(intTake && intReq)
        |=> !intVector.valid)
        else $error("vector read left valid set");
    chk_rdata_idle: assert property (
        !regReq.rd |=> regRdata == 16'h0)
        else $error("read data outside read answer");
    chk_unmapped_read: assert property (
        regReq.rd && regReq.addr == 6'h3f |=> regRdata == 16'h0)
        else $error("unmapped read not zero");
    chk_reset_quiet: assert property (
        @(posedge clk_sys) disable iff (1'b0)
        rst |-> !intReq && !intVector.valid)
        else $error("request during reset");

    cover property (intTake && intReq);
    cover property (regReq.rd && regReq.addr == 6'h03 && intVector.valid);
    cover property (intReq && regReq.wr && regReq.addr == 6'h02);
endmodule

// >>> verif/cpu_model.sv
/*
 * Core side model: accepts an open request after a chosen wait.
 * Assumes intReq is a level on clk_sys.
 */
`timescale 1ns/1ps

module cpu_model (
    input  wire logic       clk_sys,
    input  wire logic       rst,
    input  wire logic       intReq,
    input  wire logic [1:0] lat,
    output logic            intTake
);
    logic [1:0] waitCnt;

    // --------------------
    // Accept
    // --------------------
    // The wait lets the bench exercise both a prompt and a slow core.
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            intTake <= 1'b0;
            waitCnt <= 2'h0;
        end else if (intTake || !intReq) begin
            intTake <= 1'b0;
            waitCnt <= 2'h0;
        end else if (waitCnt >= lat) begin
            intTake <= 1'b1;
        end else begin
            waitCnt <= waitCnt + 2'h1;
        end
    end
endmodule

// >>> verif/tb_top.sv
/*
 * Self-checking bench of the grouped interrupt prioritizer.
 * Assumes the design package is compiled first; the core is modelled.
 */
`timescale 1ns/1ps

module tb_top
    import gip_pkg::*;
;
    logic             clk_sys = 1'b0;
    logic             rst = 1'b0;
    reg_req_t         regReq = '0;
    word_t            regRdata;
    logic [11:0][7:0] periphReq = '0;
    logic [11:0][7:0] pat;
    logic [3:0]       directLines = 4'h0;
    logic             intReq;
    logic             intTake;
    vector_t          intVector;
    logic [1:0]       lat = 2'h0;
    logic             tookPrev = 1'b0;
    logic             rdPrev = 1'b0;
    logic [15:0]      vecQ[$];
    logic [15:0]      rdQ[$];
    int               takes = 0;
    int               mismatches = 0;
    int               cmp_count = 0;
    int               cycles = 0;
    int               seed = 99;

    always #10 clk_sys = ~clk_sys;

    grouped_interrupt_prioritizer i_dut (.clk_sys, .rst, .regReq, .regRdata,
        .periphReq, .directLines, .intReq, .intTake, .intVector);
    cpu_model i_cpu (.clk_sys, .rst, .intReq, .lat, .intTake);

    // --------------------
    // Checking
    // --------------------
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            mismatches++;
            $display("Error at %0t ns: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic results();
        if (mismatches == 0 && cmp_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    always @(posedge clk_sys) begin
        cycles++;
        if (tookPrev) check({8'h0, intVector}, vecQ.pop_front());
        if (rdPrev) check(regRdata, rdQ.pop_front());
        tookPrev <= intTake && intReq;
        rdPrev <= regReq.rd;
        if (intTake && intReq) takes <= takes + 1;
        if (cycles == 5000) begin
            mismatches++;
            results();
        end
    end

    // --------------------
    // Drivers
    // --------------------
    task automatic wr(input logic [5:0] a, input word_t d);
        @(posedge clk_sys);
        regReq <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk_sys);
        regReq <= '0;
    endtask

    task automatic rd(input logic [5:0] a, input word_t exp);
        @(posedge clk_sys);
        regReq <= '{addr: a, wdata: 16'h0, wr: 1'b0, rd: 1'b1};
        rdQ.push_back(exp);
        @(posedge clk_sys);
        regReq <= '0;
    endtask

    // Counting takes rather than watching for one avoids missing a take
    // that lands while a register write is still in flight.
    task automatic serve(input int g, input int p, input logic [5:0] a,
                         input word_t d);
        int t0;
        int n;
        t0 = takes;
        vecQ.push_back({8'h0, 1'b1, 4'(g), 3'(p)});
        lat <= 2'($random(seed));
        wr(6'h02, 16'hffff);
        wr(a, d);
        wr(6'h01, 16'h0000);
        for (n = 0; n < 40 && takes == t0; n++) @(posedge clk_sys);
        check(16'(takes - t0), 16'h1);
        repeat (2) @(posedge clk_sys);
        rd(6'h03, 16'h8000 | 16'(g << 3) | 16'(p));
    endtask

    task automatic held(input int g, input int p, input logic [5:0] a,
                        input word_t d);
        wr(6'h02, 16'hffff);
        wr(6'h01, 16'h0000);
        wr(a, d);
        @(posedge clk_sys);
        periphReq[g][p] <= 1'b1;
        @(posedge clk_sys);
        periphReq <= '0;
        repeat (8) @(posedge clk_sys);
        check(16'(intReq), 16'h0);
    endtask

    // --------------------
    // Scenarios
    // --------------------
    initial begin
        // An initialiser makes no edge, so reset is raised by an update.
        rst <= 1'b1;
        repeat (3) @(posedge clk_sys);
        rst <= 1'b0;
        rd(6'h00, 16'h0000);
        rd(6'h01, 16'h0001);
        rd(6'h1b, 16'h0000);
        wr(6'h3f, 16'hffff);
        rd(6'h3f, 16'h0000);
        wr(6'h00, 16'hffff);
        for (int g = 0; g < 12; g++) wr(6'h10 + 6'(g), 16'h00ff);
        rd(6'h00, 16'hffff);
        rd(6'h1b, 16'h00ff);
        for (int g = 0; g < 12; g++) pat[g] = 8'($random(seed) & $random(seed));
        @(posedge clk_sys);
        periphReq <= pat;
        @(posedge clk_sys);
        periphReq <= '0;
        for (int g = 0; g < 12; g++) begin
            rd(6'h20 + 6'(g), {8'h00, pat[g]});
        end
        for (int g = 0; g < 12; g++) begin
            for (int p = 0; p < 8; p++) begin
                if (pat[g][p]) serve(g, p, 6'h3f, 16'hffff);
            end
        end
        @(posedge clk_sys);
        periphReq[3] <= 8'h21;
        @(posedge clk_sys);
        periphReq <= '0;
        serve(3, 0, 6'h3f, 16'hffff);
        rd(6'h02, 16'h0008);
        wr(6'h01, 16'h0000);
        repeat (8) @(posedge clk_sys);
        check(16'(intReq), 16'h0);
        serve(3, 5, 6'h3f, 16'hffff);
        held(4, 2, 6'h14, 16'h00fb);
        serve(4, 2, 6'h14, 16'h00ff);
        held(5, 0, 6'h00, 16'hffdf);
        serve(5, 0, 6'h00, 16'hffff);
        held(6, 7, 6'h01, 16'h0001);
        serve(6, 7, 6'h01, 16'h0000);
        wr(6'h01, 16'h0001);
        directLines <= 4'h2;
        serve(13, 0, 6'h3f, 16'hffff);
        rd(6'h04, 16'h2000);
        directLines <= 4'h0;
        @(posedge clk_sys);
        rst <= 1'b1;
        repeat (3) @(posedge clk_sys);
        rst <= 1'b0;
        rd(6'h01, 16'h0001);
        rd(6'h00, 16'h0000);
        results();
    end
endmodule

bind grouped_interrupt_prioritizer gip_chk i_chk (.clk_sys, .rst, .regReq,
    .regRdata, .periphReq, .directLines, .intReq, .intTake, .intVector);
